// ### core/uotec_defs.vh
// Purpose: Constants for the token, frame and endpoint configuration block
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes: Only the low byte of each register is implemented, plus the write-only device address in control bits 14..8
`ifndef UOTEC_DEFS_VH
`define UOTEC_DEFS_VH

// Register byte offsets
`define UOTEC_OFS_TOKEN 8'h00
`define UOTEC_OFS_SOFTHR 8'h04
`define UOTEC_OFS_BASELO 8'h08
`define UOTEC_OFS_BASEMID 8'h0C
`define UOTEC_OFS_BASEHI 8'h10
`define UOTEC_OFS_CFG1 8'h14
`define UOTEC_OFS_CTRL 8'h18
`define UOTEC_OFS_STATUS 8'h1C
`define UOTEC_OFS_EP0 8'h40
`define UOTEC_EP_COUNT 16

// Reset value of every implemented register
`define UOTEC_RST_BYTE 8'h00

// Token type codes
`define UOTEC_PID_SETUP 4'hD
`define UOTEC_PID_IN 4'h9
`define UOTEC_PID_OUT 4'h1

// Configuration one fields
`define UOTEC_CFG_EYE 7
`define UOTEC_CFG_OEMON 6
`define UOTEC_CFG_SIDL 4
`define UOTEC_CFG_ASUSP 0
`define UOTEC_CFG_MASK 8'hD1

// Control register fields
`define UOTEC_CTL_HOSTEN 0
`define UOTEC_CTL_FRAME_TOKEN_ENABLE 1
`define UOTEC_CTL_SUSP 2

// Endpoint control fields
`define UOTEC_EP_LOW_SPEED_DIRECT 7
`define UOTEC_EP_NORETRY 6
`define UOTEC_EP_CONDIS 4
`define UOTEC_EP_RXEN 3
`define UOTEC_EP_TXEN 2
`define UOTEC_EP_STALL 1
`define UOTEC_EP_HSHK 0
`define UOTEC_EP_MASK 8'hDF

// Frame timing
`define UOTEC_CLK_MHZ 10
`define UOTEC_SOF_PERIOD_US 1000
`define UOTEC_SOF_CYCLES (`UOTEC_SOF_PERIOD_US * `UOTEC_CLK_MHZ)

`endif

// ### core/uotec_regs.v
// Purpose: Software view of host token, frame threshold, descriptor base,
//          module configuration and sixteen endpoint controls
// Assumes: Avalon-MM slave on clk, synchronous active-high rst
// Notes: Each access takes one wait cycle; unmapped reads return zero
//
// Behaviour
// - Token type bits 7..4 code SETUP 1101, IN 1001, OUT 0001.
// - Base address bits 15..9 come from low page bits 7..1; bit 0 zero.
// - Base address bits 23..16 come from the middle page register.
// - Base address bits 31..24 come from the high page register.
// - Base address is 512-byte aligned; bits 8..0 always zero.
// - Configuration bit 7 runs the eye-pattern test.
// - Configuration bit 6 enables the output-enable monitor signal.
// - Configuration bit 4 halts the module while in Idle.
// - Configuration bit 0 suspends automatically on entry to Sleep.
// - Otherwise only the manual suspend bit suspends, stopping USB clock.
// - Host endpoint 0 bit 7 selects direct low-speed, else hub preamble.
// - Host endpoint 0 bit 6 clear retries NAKs; set disables retries.
// - With TX and RX enabled, bit 4 refuses SETUP; otherwise ignored.
// - Endpoint receives only with bit 3, transmits only with bit 2.
// - Endpoint bit 1 reports that the endpoint was stalled.
// - Endpoint handshakes happen only while bit 0 is set.
// - Register bits 31..8 read as zero.
// - In host mode with frame enable, send a frame token every 1 ms.
//
// The Avalon-MM slave port and the register addresses were decided locally.

`timescale 1ns/1ps
`default_nettype none
`include "uotec_defs.vh"

module uotec_regs #(
  parameter SOF_CYCLES = `UOTEC_SOF_CYCLES,
  parameter SOF_CW = 14
) (
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Power state of the surrounding chip
  input wire idleMode,
  input wire sleepMode,
  // Transceiver and engine status
  input wire xcvrDriving,
  input wire tokenDone,
  input wire [15:0] stallEvent,
  // Host token request
  output reg tokenStart,
  output reg [3:0] tokenPid,
  output reg [3:0] tokenEndpoint,
  output reg [6:0] tokenAddress,
  output reg tokenInProgress,
  output reg frameTokenStart,
  output reg [7:0] frameThresholdCount,
  output reg [31:0] descBaseAddress,
  // Module configuration
  output reg eyePatternTest,
  output reg outputEnableMonitor,
  output reg usbHalted,
  output reg usbSuspended,
  output reg usbClockEnable,
  output reg lowSpeedDirect,
  output reg nakRetryEnable,
  // Per-endpoint permissions
  output reg [15:0] endpointReceiveAllow,
  output reg [15:0] endpointTransmitAllow,
  output reg [15:0] endpointSetupAllow,
  output reg [15:0] endpointHandshakeEnable
);

  localparam [SOF_CW-1:0] SOF_LAST = SOF_CYCLES - 1;

  // Register storage, low byte only
  reg [7:0] tokenCmd;
  reg [7:0] frameThreshold;
  reg [7:0] descBaseLow;
  reg [7:0] descBaseMid;
  reg [7:0] descBaseHigh;
  reg [7:0] configOne;
  reg [7:0] controlReg;
  reg [6:0] deviceAddress;
  reg [7:0] endpointCtrl [0:15];
  reg [SOF_CW-1:0] sofCount;

  wire accept;
  wire writeHit;
  wire laneLow;
  wire isEpAddr;
  wire [3:0] epIndex;
  wire hostMode;
  wire validPid;
  wire suspendNow;
  wire haltNow;
  reg [7:0] next_readByte;

  // One wait cycle per access; the transfer completes when waitrequest low
  assign accept = (read | write) & ~waitrequest;
  assign writeHit = write & ~waitrequest;
  assign laneLow = byteenable[0];
  assign isEpAddr = (address[7:6] == 2'b01);
  assign epIndex = address[5:2];
  assign hostMode = controlReg[`UOTEC_CTL_HOSTEN];
  assign validPid = (writedata[7:4] == `UOTEC_PID_SETUP) |
                    (writedata[7:4] == `UOTEC_PID_IN) |
                    (writedata[7:4] == `UOTEC_PID_OUT);
  // Manual suspend works in both modes; auto only while sleeping
  assign suspendNow = controlReg[`UOTEC_CTL_SUSP] |
                      (configOne[`UOTEC_CFG_ASUSP] & sleepMode);
  assign haltNow = configOne[`UOTEC_CFG_SIDL] & idleMode;

  // Bus handshake: wait for one cycle, then release for the transfer
  always @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end

  // Read mux; upper bits of every register are tied to zero
  always @* begin
    next_readByte = `UOTEC_RST_BYTE;
    if (isEpAddr) begin
      next_readByte = endpointCtrl[epIndex];
    end else begin
      case (address)
        `UOTEC_OFS_TOKEN: next_readByte = tokenCmd;
        `UOTEC_OFS_SOFTHR: next_readByte = frameThreshold;
        `UOTEC_OFS_BASELO: next_readByte = {descBaseLow[7:1], 1'b0};
        `UOTEC_OFS_BASEMID: next_readByte = descBaseMid;
        `UOTEC_OFS_BASEHI: next_readByte = descBaseHigh;
        `UOTEC_OFS_CFG1: next_readByte = configOne;
        `UOTEC_OFS_CTRL: next_readByte = {5'b0_0000, controlReg[2:0]};
        `UOTEC_OFS_STATUS: next_readByte = {6'b00_0000, usbSuspended,
                                           tokenInProgress};
        default: next_readByte = `UOTEC_RST_BYTE;
      endcase
    end
  end

  // Read data is captured in the wait cycle so it stands at the release
  always @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & waitrequest) begin
      readdata <= {24'h00_0000, next_readByte};
    end
  end

  // Scalar configuration registers
  always @(posedge clk) begin
    if (rst) begin
      frameThreshold <= `UOTEC_RST_BYTE;
      descBaseLow <= `UOTEC_RST_BYTE;
      descBaseMid <= `UOTEC_RST_BYTE;
      descBaseHigh <= `UOTEC_RST_BYTE;
      configOne <= `UOTEC_RST_BYTE;
      controlReg <= `UOTEC_RST_BYTE;
      deviceAddress <= 7'h00;
    end else if (writeHit & laneLow) begin
      case (address)
        `UOTEC_OFS_SOFTHR: frameThreshold <= writedata[7:0];
        `UOTEC_OFS_BASELO: descBaseLow <= {writedata[7:1], 1'b0};
        `UOTEC_OFS_BASEMID: descBaseMid <= writedata[7:0];
        `UOTEC_OFS_BASEHI: descBaseHigh <= writedata[7:0];
        `UOTEC_OFS_CFG1: configOne <= writedata[7:0] & `UOTEC_CFG_MASK;
        `UOTEC_OFS_CTRL: controlReg <= {5'b0_0000, writedata[2:0]};
        `UOTEC_OFS_STATUS: deviceAddress <= deviceAddress;
        default: deviceAddress <= deviceAddress;
      endcase
      if (address == `UOTEC_OFS_CTRL) begin
        deviceAddress <= writedata[14:8] ;
      end
    end
  end

  // Token register; a host-mode write with a defined code launches it unless halted or suspended.
  // Reserved codes are stored but never launched, so the engine never
  // sees a type it cannot decode.
  always @(posedge clk) begin
    if (rst) begin
      tokenCmd <= `UOTEC_RST_BYTE;
      tokenStart <= 1'b0;
      tokenPid <= 4'h0;
      tokenEndpoint <= 4'h0;
      tokenAddress <= 7'h00;
    end else begin
      tokenStart <= 1'b0;
      if (writeHit & laneLow & (address == `UOTEC_OFS_TOKEN)) begin
        tokenCmd <= writedata[7:0];
        if (hostMode & validPid & ~haltNow & ~suspendNow) begin
          tokenStart <= 1'b1;
          tokenPid <= writedata[7:4];
          tokenEndpoint <= writedata[3:0];
          tokenAddress <= deviceAddress;
        end
      end
    end
  end

  // Busy flag; a launch in the same cycle as done keeps it set
  always @(posedge clk) begin
    if (rst) begin
      tokenInProgress <= 1'b0;
    end else if (tokenStart) begin
      tokenInProgress <= 1'b1;
    end else if (tokenDone | ~hostMode) begin
      tokenInProgress <= 1'b0;
    end
  end

  // Frame timer: counts only while the host is running; cleared in suspend
  always @(posedge clk) begin
    if (rst) begin
      sofCount <= {SOF_CW{1'b0}};
      frameTokenStart <= 1'b0;
    end else begin
      frameTokenStart <= 1'b0;
      if (~hostMode | ~controlReg[`UOTEC_CTL_FRAME_TOKEN_ENABLE] | haltNow | suspendNow)
      begin
        sofCount <= {SOF_CW{1'b0}};
      end else if (sofCount == SOF_LAST) begin
        sofCount <= {SOF_CW{1'b0}};
        frameTokenStart <= 1'b1;
      end else begin
        sofCount <= sofCount + 1'b1;
      end
    end
  end

  // Derived configuration outputs, all registered
  always @(posedge clk) begin
    if (rst) begin
      frameThresholdCount <= `UOTEC_RST_BYTE;
      descBaseAddress <= 32'h0000_0000;
      eyePatternTest <= 1'b0;
      outputEnableMonitor <= 1'b0;
      usbHalted <= 1'b0;
      usbSuspended <= 1'b0;
      usbClockEnable <= 1'b1;
      lowSpeedDirect <= 1'b0;
      nakRetryEnable <= 1'b0;
    end else begin
      frameThresholdCount <= frameThreshold;
      descBaseAddress <= {descBaseHigh, descBaseMid, descBaseLow[7:1],
                          9'h000};
      eyePatternTest <= configOne[`UOTEC_CFG_EYE];
      outputEnableMonitor <= configOne[`UOTEC_CFG_OEMON] &
                             xcvrDriving;
      usbHalted <= haltNow;
      usbSuspended <= suspendNow;
      usbClockEnable <= ~suspendNow;
      lowSpeedDirect <= hostMode &
                        endpointCtrl[0][`UOTEC_EP_LOW_SPEED_DIRECT];
      nakRetryEnable <= hostMode &
                        ~endpointCtrl[0][`UOTEC_EP_NORETRY];
    end
  end

  // One endpoint register and its permission outputs per index
  genvar gi;
  generate
    for (gi = 0; gi < `UOTEC_EP_COUNT; gi = gi + 1) begin : gEp
      wire epWrite;
      wire [7:0] epNow;
      assign epWrite = writeHit & laneLow & isEpAddr &
                       (epIndex == gi[3:0]);
      assign epNow = endpointCtrl[gi];

      // Stall status: hardware set beats a software clear in one cycle
      always @(posedge clk) begin
        if (rst) begin
          endpointCtrl[gi] <= `UOTEC_RST_BYTE;
        end else if (epWrite) begin
          endpointCtrl[gi] <= (writedata[7:0] & `UOTEC_EP_MASK) |
                              {6'b00_0000, stallEvent[gi], 1'b0};
        end else if (stallEvent[gi]) begin
          endpointCtrl[gi][`UOTEC_EP_STALL] <= 1'b1;
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          endpointReceiveAllow[gi] <= 1'b0;
          endpointTransmitAllow[gi] <= 1'b0;
          endpointSetupAllow[gi] <= 1'b0;
          endpointHandshakeEnable[gi] <= 1'b0;
        end else begin
          endpointReceiveAllow[gi] <= epNow[`UOTEC_EP_RXEN];
          endpointTransmitAllow[gi] <= epNow[`UOTEC_EP_TXEN];
          // Condis only counts when both directions are on
          endpointSetupAllow[gi] <= epNow[`UOTEC_EP_RXEN] &
                                    epNow[`UOTEC_EP_TXEN] &
                                    ~epNow[`UOTEC_EP_CONDIS];
          endpointHandshakeEnable[gi] <= epNow[`UOTEC_EP_HSHK];
        end
      end
    end
  endgenerate

endmodule // uotec_regs

`default_nettype wire

// ### core/uotec_empty_guard.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### verification/uotec_regs_asserts.sv
// Purpose: Concurrent checks on the uotec_regs ports
// Assumes: One clock, synchronous active-high rst
// Notes: Bound to every uotec_regs instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "uotec_defs.vh"
module uotec_regs_asserts #(
  parameter SOF_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic tokenStart,
  input wire logic [3:0] tokenPid,
  input wire logic tokenInProgress,
  input wire logic frameTokenStart,
  input wire logic [31:0] descBaseAddress,
  input wire logic usbSuspended,
  input wire logic usbClockEnable
);
  logic [15:0] gap;
  logic seen;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Gap since last frame token; a held counter only lengthens it
  always @(posedge clk) begin
    gap <= frameTokenStart ? 16'h0000 : gap + 16'h0001;
    seen <= !rst && (seen || frameTokenStart);
  end
  sequence s_base_low_wr;
    write && !waitrequest && address == `UOTEC_OFS_BASELO && byteenable[0];
  endsequence
  sequence s_token_wr;
    write && !waitrequest && address[7:2] == 6'h00;
  endsequence
  AST_RD_UPPER: assert property (!waitrequest |-> readdata[31:8] == '0)
    else $error("upper read bits set");
  AST_TOK_CAUSE: assert property (tokenStart |-> $past(write && !waitrequest && address[7:2] == 6'h00))
    else $error("launch without token write");
  AST_TOK_PID: assert property (tokenStart |-> tokenPid inside {4'hD, 4'h9, 4'h1})
    else $error("reserved token launched");
  AST_TOK_BUSY: assert property (s_token_wr ##1 tokenStart |=> tokenInProgress)
    else $error("busy not raised");
  AST_BASE_LOW: assert property (s_base_low_wr |=> ##1 descBaseAddress[15:9] == $past(writedata[7:1], 2))
    else $error("base low bits wrong");
  AST_ALIGN: assert property (descBaseAddress[8:0] == '0)
    else $error("base not aligned");
  AST_CLK_STOP: assert property (usbClockEnable != usbSuspended)
    else $error("clock runs while suspended");
  AST_SOF_GAP: assert property (frameTokenStart && seen |-> gap >= SOF_CYCLES - 1)
    else $error("frame tokens too close");
endmodule // uotec_regs_asserts
bind uotec_regs uotec_regs_asserts #(.SOF_CYCLES(SOF_CYCLES)) i_chk (.clk, .rst,
  .address, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .tokenStart, .tokenPid, .tokenInProgress, .frameTokenStart,
  .descBaseAddress, .usbSuspended, .usbClockEnable);
`default_nettype wire

// ### verification/uotec_engine_model.sv
// Purpose: Transaction engine that answers launched tokens
// Assumes: delay input sets how long the line is driven
// Notes: delay 0 answers promptly, larger values stall software
`timescale 1ns/1ps
`default_nettype none
module uotec_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic tokenStart,
  input wire logic [3:0] delay,
  output logic tokenDone,
  output logic xcvrDriving
);
  logic [3:0] cnt;
  // Drive the line for delay plus one cycles, then report the token finished
  always @(posedge clk) begin
    tokenDone <= 1'b0;
    if (rst) begin
      cnt <= '0;
      xcvrDriving <= 1'b0;
    end else if (tokenStart) begin
      cnt <= delay;
      xcvrDriving <= 1'b1;
    end else if (xcvrDriving) begin
      cnt <= cnt - 4'h1;
      xcvrDriving <= cnt != 4'h0;
      tokenDone <= cnt == 4'h0;
    end
  end
endmodule // uotec_engine_model
`default_nettype wire

// ### verification/usb_otg_token_endpoint_config_test.sv
// Purpose: Self-checking bench for the token and endpoint config block
// Assumes: Frame period shortened to 20 cycles
// Notes: Seeded random register traffic plus corner cases
`timescale 1ns/1ps
`default_nettype none
`include "uotec_defs.vh"
module usb_otg_token_endpoint_config_test;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
  logic idleMode = 1'b0, sleepMode = 1'b0, xcvrDriving, tokenDone, tokenStart;
  logic [7:0] address = '0, frameThresholdCount, regv [0:21];
  logic [31:0] writedata = '0, readdata, q, d, descBaseAddress;
  logic [3:0] byteenable = 4'hF, be, pid, ep, dly = '0, tokenPid, tokenEndpoint;
  logic [15:0] stallEvent = '0, endpointReceiveAllow, endpointTransmitAllow;
  logic [15:0] endpointSetupAllow, endpointHandshakeEnable;
  logic [6:0] tokenAddress;
  logic tokenInProgress, frameTokenStart, eyePatternTest, outputEnableMonitor;
  logic usbHalted, usbSuspended, usbClockEnable, lowSpeedDirect, nakRetryEnable;
  int error_cnt = 0, num_checks = 0, seed = 32'h9c4b_2bc2;
  int cyc = 0, starts = 0, frames = 0, n;
  uotec_regs #(.SOF_CYCLES(20)) i_dut (.clk, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .idleMode, .sleepMode,
    .xcvrDriving, .tokenDone, .stallEvent, .tokenStart, .tokenPid,
    .tokenEndpoint, .tokenAddress, .tokenInProgress, .frameTokenStart,
    .frameThresholdCount, .descBaseAddress, .eyePatternTest,
    .outputEnableMonitor, .usbHalted, .usbSuspended, .usbClockEnable,
    .lowSpeedDirect, .nakRetryEnable, .endpointReceiveAllow,
    .endpointTransmitAllow, .endpointSetupAllow, .endpointHandshakeEnable);
  uotec_engine_model i_eng (.clk, .rst, .tokenStart, .delay(dly), .tokenDone,
    .xcvrDriving);
  // Register index to byte address and writable mask
  function automatic logic [7:0] adr(int r);
    return r < 6 ? 8'(4 * r) : 8'(8'h40 + 4 * (r - 6));
  endfunction
  function automatic logic [7:0] msk(int r);
    return r == 2 ? 8'hFE : r == 5 ? 8'hD1 : r > 5 ? 8'hDF : 8'hFF;
  endfunction
  // Expected endpoint vector; b == 4 means setup permitted
  function automatic logic [15:0] epv(int b);
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v[i] = b == 4 ? regv[6+i][3] & regv[6+i][2] & ~regv[6+i][4] : regv[6+i][b];
    end
    return v;
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Avalon master: hold the request until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] v,
           input logic [3:0] b);
    @(posedge clk);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= v;
    byteenable <= b;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  initial forever #50 clk = ~clk;
  // Event counters and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    starts <= starts + (tokenStart === 1'b1);
    frames <= frames + (frameTokenStart === 1'b1);
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 22; r++) begin
      bus(0, adr(r), '0, 4'hF);
      check("reset", q, '0);
      regv[r] = '0;
    end
    bus(1, 8'h30, '1, 4'hF);
    bus(0, 8'h30, '0, 4'hF);
    check("unmapped", q, '0);
    // Random writes, some with the low byte lane off
    repeat (3) begin
      for (int r = 0; r < 22; r++) begin
        d = $random(seed);
        be = $random(seed);
        bus(1, adr(r), d, be);
        if (be[0]) regv[r] = d[7:0] & msk(r);
      end
      for (int r = 0; r < 22; r++) begin
        bus(0, adr(r), '0, 4'hF);
        check("readback", q, {24'h0, regv[r]});
      end
      repeat (2) @(posedge clk);
      check("base", descBaseAddress, {regv[4], regv[3], regv[2][7:1], 9'h0});
      check("threshold", frameThresholdCount, regv[1]);
      check("eye", eyePatternTest, regv[5][7]);
      check("setup", endpointSetupAllow, epv(4));
      check("rx", endpointReceiveAllow, epv(3));
      check("tx", endpointTransmitAllow, epv(2));
      check("handshake", endpointHandshakeEnable, epv(0));
    end
    ep = $random(seed);
    bus(1, adr(6 + ep), '0, 4'hF);
    stallEvent <= 16'h0001 << ep;
    @(posedge clk);
    stallEvent <= '0;
    bus(0, adr(6 + ep), '0, 4'hF);
    check("stall", q[1], 1'b1);
    // Host mode, address 5A, frames on, low-speed direct, retries on
    bus(1, `UOTEC_OFS_SOFTHR, 32'h0000_004A, 4'hF);
    bus(1, `UOTEC_OFS_CFG1, 32'h0000_0040, 4'hF);
    bus(1, `UOTEC_OFS_EP0, 32'h0000_0080, 4'hF);
    bus(1, `UOTEC_OFS_CTRL, 32'h0000_5A03, 4'hF);
    repeat (2) @(posedge clk);
    check("lowspeed", lowSpeedDirect, 1'b1);
    check("retry", nakRetryEnable, 1'b1);
    for (int i = 0; i < 4; i++) begin
      pid = i == 0 ? 4'hD : i == 1 ? 4'h9 : i == 2 ? 4'h1 : 4'h5;
      do bus(0, `UOTEC_OFS_STATUS, '0, 4'hF); while (q[0] !== 1'b0);
      n = starts;
      ep = $random(seed);
      dly <= $random(seed);
      bus(1, `UOTEC_OFS_TOKEN, {24'h0, pid, ep}, 4'hF);
      repeat (3) @(posedge clk);
      check("launch", starts - n, i < 3);
      check("oe monitor", outputEnableMonitor, i < 3);
      if (i < 3) begin
        check("pid", tokenPid, pid);
        check("ep", tokenEndpoint, ep);
        check("addr", tokenAddress, 7'h5A);
      end
    end
    n = frames;
    repeat (100) @(posedge clk);
    check("frames", frames - n, 5);
    bus(1, `UOTEC_OFS_CFG1, 32'h0000_0010, 4'hF);
    idleMode <= 1'b1;
    repeat (2) @(posedge clk);
    n = frames;
    check("halt", usbHalted, 1'b1);
    repeat (40) @(posedge clk);
    check("halted frames", frames - n, 0);
    idleMode <= 1'b0;
    sleepMode <= 1'b1;
    bus(1, `UOTEC_OFS_CFG1, 32'h0000_0001, 4'hF);
    repeat (2) @(posedge clk);
    check("auto suspend", usbSuspended, 1'b1);
    check("usb clock", usbClockEnable, 1'b0);
    bus(1, `UOTEC_OFS_CFG1, '0, 4'hF);
    repeat (2) @(posedge clk);
    check("no suspend", usbSuspended, 1'b0);
    bus(1, `UOTEC_OFS_CTRL, 32'h0000_0004, 4'hF);
    repeat (2) @(posedge clk);
    check("manual suspend", usbSuspended, 1'b1);
    check("manual clock", usbClockEnable, 1'b0);
    give_verdict();
  end
endmodule // usb_otg_token_endpoint_config_test
`default_nettype wire
